// file: design/ssf_pkg.sv
// package of constants and carriers for the serial status flag block
package ssf_pkg;
	// register map, byte addresses on apb
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_TXDATA = 8'h04;
	localparam logic [7:0] ADDR_RXDATA = 8'h08;
	localparam logic [7:0] ADDR_CTRL = 8'h0c;
	// status field positions
	localparam int BIT_TX_HOLDING_EMPTY_FLAG = 7;
	localparam int BIT_RX_HOLDING_FULL_FLAG = 6;
	localparam int BIT_RX_OVERRUN_FLAG = 5;
	localparam int BIT_FER = 4;
	localparam int BIT_PER = 3;
	localparam int BIT_TX_COMPLETE_FLAG = 2;
	localparam int BIT_MPB = 1;
	localparam int BIT_TX_MULTIPROC_BIT = 0;
	// control field positions
	localparam int CTL_TE = 0;
	localparam int CTL_RE = 1;
	localparam int CTL_SYNC = 2;
	localparam int CTL_MP = 3;
	localparam int CTL_ODD = 4;
	localparam int CTL_PAR = 5;
	localparam int CTL_STBY = 6;
	// reset values
	localparam logic [7:0] STATUS_RESET = 8'h84;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// one received character as the shifter hands it over
	typedef struct packed {
		logic [7:0] data;
		logic parity_bit;
		logic mp_bit;
		logic stop1;
		logic stop2;
	} ssf_rx_char_type;
	// events from the transmit shifter
	typedef struct packed {
		logic load;
		logic last_bit;
	} ssf_tx_evt_type;
endpackage : ssf_pkg

// file: design/ssf_clr_qual.sv
// read-before-clear qualification for one status flag
`timescale 1ns/1ps
module ssf_clr_qual (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// flag and software access
	input wire logic flag,
	input wire logic rd,
	input wire logic wr0,
	input wire logic hw_set,
	input wire logic force_off,
	// qualified clear
	output logic clr
);
	logic armed_r;
	// a write of 0 only clears once a 1 has been seen by a read
	assign clr = armed_r & wr0 & ~hw_set; // see RULE2 see RULE24
	// arm on read of 1, disarm once the flag is cleared
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			armed_r <= 1'b0;
		end else if (force_off | clr | ~flag) begin
			armed_r <= 1'b0; // see RULE25
		end else if (rd & flag) begin
			armed_r <= 1'b1;
		end
	end
endmodule : ssf_clr_qual

// file: design/ssf_status.sv
// serial channel status register with apb access and flag logic
//
// Operation
// RULE1 - writing 1 to a status flag does nothing
// RULE2 - write 0 clears only after reading 1
// RULE3 - transmit-end and rx multiproc bit read-only
// RULE4 - reset and standby load status 0x84
// RULE5 - tx empty clears by sw or dma write
// RULE6 - tx empty sets on disable or load
// RULE7 - rx full clears by sw, dma, standby
// RULE8 - rx full sets on good character
// RULE9 - errors and rx disable keep data, flag
// RULE10 - overrun when character ends with full set
// RULE11 - overrun keeps old receive data
// RULE12 - overrun clears only reset, standby, sw
// RULE13 - rx disable keeps overrun flag
// RULE14 - overrun stops rx, sync also tx
// RULE15 - async stop bit zero sets framing error
// RULE16 - only first stop bit is checked
// RULE17 - framing error loads data, no full flag
// RULE18 - framing error halts rx, sync tx
// RULE19 - framing clears only reset, standby, sw
// RULE20 - parity mismatch sets parity error flag
// RULE21 - transmit-end sets on empty last bit
// RULE22 - rx multiproc bit holds last received
// RULE23 - tx multiproc bit read-write, feeds transmitter
// RULE24 - hardware set wins over clear
// RULE25 - clear qualification tracked per flag
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
module ssf_status (
	// apb slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// dma controller strobes, same clock
	input wire logic dma_tx_write,
	input wire logic [7:0] dma_tx_data,
	input wire logic dma_rx_read,
	// shifter side, same clock
	input wire ssf_pkg::ssf_tx_evt_type tx_evt,
	input wire logic rx_done,
	input wire ssf_pkg::ssf_rx_char_type rx_char,
	// to shifters
	output logic [7:0] tx_holding_reg,
	output logic tx_multiproc_bit,
	output logic transmitter_enable,
	output logic receiver_enable,
	output logic tx_allowed,
	output logic rx_allowed
);
	//////////////////////////////////////////////////////////////////////
	logic [7:0] status_r;
	logic [6:0] ctrl_r;
	logic [7:0] rx_holding_reg_r;
	logic [7:0] tx_holding_reg_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic standby;
	logic sync_mode;
	logic acc;
	logic wr_st;
	logic rd_st;
	logic wr_tx;
	logic rd_rx;
	logic [4:0] qclr;
	logic te_fall;
	logic te_q_r;
	logic rx_err_block;
	logic rx_ok;
	logic par_bad;
	logic fer_set;
	logic per_set;
	logic rx_overrun_flag_set;
	logic rx_holding_full_flag_set;
	logic tx_holding_empty_flag_set;
	logic tx_complete_flag_set;
	logic [7:0] rdata_nxt;
	//////////////////////////////////////////////////////////////////////
	// apb access qualifiers; answer is a single access phase with one wait state
	assign acc = psel & penable & ~pready_r;
	assign wr_st = acc & pwrite & (paddr == ssf_pkg::ADDR_STATUS);
	assign rd_st = acc & ~pwrite & (paddr == ssf_pkg::ADDR_STATUS);
	assign wr_tx = acc & pwrite & (paddr == ssf_pkg::ADDR_TXDATA);
	assign rd_rx = acc & ~pwrite & (paddr == ssf_pkg::ADDR_RXDATA);
	assign standby = ctrl_r[ssf_pkg::CTL_STBY];
	assign sync_mode = ctrl_r[ssf_pkg::CTL_SYNC];
	// an event, not a level: a held-low enable must not block the software clear
	assign te_fall = te_q_r & ~ctrl_r[ssf_pkg::CTL_TE]; // see RULE6 see RULE21

	// previous transmit enable, for the falling edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			te_q_r <= ssf_pkg::CTRL_RESET[ssf_pkg::CTL_TE];
		end else begin
			te_q_r <= ctrl_r[ssf_pkg::CTL_TE];
		end
	end

	// even count of ones including parity bit fails odd, and vice versa
	function automatic logic parity_mismatch(input logic [7:0] d, input logic p, input logic odd);
		parity_mismatch = (^{d, p}) != odd;
	endfunction : parity_mismatch

	// receive event classification
	assign rx_err_block = status_r[ssf_pkg::BIT_RX_OVERRUN_FLAG] | status_r[ssf_pkg::BIT_FER]
		| status_r[ssf_pkg::BIT_PER]; // see RULE14 see RULE18
	assign rx_ok = rx_done & ctrl_r[ssf_pkg::CTL_RE] & ~rx_err_block;
	// second stop bit is never looked at
	assign fer_set = rx_ok & ~sync_mode & ~rx_char.stop1; // see RULE15 see RULE16
	assign par_bad = ctrl_r[ssf_pkg::CTL_PAR]
		& parity_mismatch(rx_char.data, rx_char.parity_bit, ctrl_r[ssf_pkg::CTL_ODD]);
	assign per_set = rx_ok & ~sync_mode & par_bad; // see RULE20
	assign rx_overrun_flag_set = rx_ok & status_r[ssf_pkg::BIT_RX_HOLDING_FULL_FLAG]; // see RULE10
	assign rx_holding_full_flag_set = rx_ok & ~status_r[ssf_pkg::BIT_RX_HOLDING_FULL_FLAG] & ~fer_set & ~per_set; // see RULE8
	assign tx_holding_empty_flag_set = te_fall | tx_evt.load; // see RULE6
	assign tx_complete_flag_set = te_fall | (tx_evt.last_bit & status_r[ssf_pkg::BIT_TX_HOLDING_EMPTY_FLAG]); // see RULE21

	// one qualifier per clearable flag, index 4..0 = tx_holding_empty_flag, rx_holding_full_flag, rx_overrun_flag, fer, per
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_qual
			logic set_i;
			assign set_i = (gi == 4) ? tx_holding_empty_flag_set : (gi == 3) ? rx_holding_full_flag_set :
				(gi == 2) ? rx_overrun_flag_set : (gi == 1) ? fer_set : per_set;
			ssf_clr_qual u_qual (
				.pclk(pclk),
				.presetn(presetn),
				.flag(status_r[ssf_pkg::BIT_PER + gi]),
				.rd(rd_st),
				.wr0(wr_st & ~pwdata[ssf_pkg::BIT_PER + gi]), // see RULE1
				.hw_set(set_i),
				.force_off(standby),
				.clr(qclr[gi])
			);
		end
	endgenerate

	// transmit empty flag; dma write of holding register clears it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_r[ssf_pkg::BIT_TX_HOLDING_EMPTY_FLAG] <= ssf_pkg::STATUS_RESET[ssf_pkg::BIT_TX_HOLDING_EMPTY_FLAG]; // see RULE4
		end else if (standby | tx_holding_empty_flag_set) begin
			status_r[ssf_pkg::BIT_TX_HOLDING_EMPTY_FLAG] <= 1'b1; // see RULE6 see RULE24
		end else if (qclr[4] | dma_tx_write) begin
			status_r[ssf_pkg::BIT_TX_HOLDING_EMPTY_FLAG] <= 1'b0; // see RULE5
		end
	end

	// receive full flag; unchanged by errors and rx disable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_r[ssf_pkg::BIT_RX_HOLDING_FULL_FLAG] <= ssf_pkg::STATUS_RESET[ssf_pkg::BIT_RX_HOLDING_FULL_FLAG];
		end else if (standby) begin
			status_r[ssf_pkg::BIT_RX_HOLDING_FULL_FLAG] <= 1'b0; // see RULE7
		end else if (rx_holding_full_flag_set) begin
			status_r[ssf_pkg::BIT_RX_HOLDING_FULL_FLAG] <= 1'b1; // see RULE8 see RULE24
		end else if (qclr[3] | dma_rx_read) begin
			status_r[ssf_pkg::BIT_RX_HOLDING_FULL_FLAG] <= 1'b0; // see RULE7 see RULE9
		end
	end

	// overrun flag; receiver enable is not looked at when clearing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_r[ssf_pkg::BIT_RX_OVERRUN_FLAG] <= ssf_pkg::STATUS_RESET[ssf_pkg::BIT_RX_OVERRUN_FLAG];
		end else if (standby) begin
			status_r[ssf_pkg::BIT_RX_OVERRUN_FLAG] <= 1'b0; // see RULE12
		end else if (rx_overrun_flag_set) begin
			status_r[ssf_pkg::BIT_RX_OVERRUN_FLAG] <= 1'b1; // see RULE24
		end else if (qclr[2]) begin
			status_r[ssf_pkg::BIT_RX_OVERRUN_FLAG] <= 1'b0; // see RULE12 see RULE13
		end
	end

	// framing error flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_r[ssf_pkg::BIT_FER] <= ssf_pkg::STATUS_RESET[ssf_pkg::BIT_FER];
		end else if (standby) begin
			status_r[ssf_pkg::BIT_FER] <= 1'b0; // see RULE19
		end else if (fer_set) begin
			status_r[ssf_pkg::BIT_FER] <= 1'b1; // see RULE15 see RULE24
		end else if (qclr[1]) begin
			status_r[ssf_pkg::BIT_FER] <= 1'b0; // see RULE19
		end
	end

	// parity error flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_r[ssf_pkg::BIT_PER] <= ssf_pkg::STATUS_RESET[ssf_pkg::BIT_PER];
		end else if (standby) begin
			status_r[ssf_pkg::BIT_PER] <= 1'b0;
		end else if (per_set) begin
			status_r[ssf_pkg::BIT_PER] <= 1'b1; // see RULE20 see RULE24
		end else if (qclr[0]) begin
			status_r[ssf_pkg::BIT_PER] <= 1'b0;
		end
	end

	// transmit end: read-only, cleared alongside the tx empty flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_r[ssf_pkg::BIT_TX_COMPLETE_FLAG] <= ssf_pkg::STATUS_RESET[ssf_pkg::BIT_TX_COMPLETE_FLAG];
		end else if (standby | tx_complete_flag_set) begin
			status_r[ssf_pkg::BIT_TX_COMPLETE_FLAG] <= 1'b1; // see RULE21 see RULE3
		end else if (qclr[4] | dma_tx_write) begin
			status_r[ssf_pkg::BIT_TX_COMPLETE_FLAG] <= 1'b0;
		end
	end

	// received multiproc bit: read-only, kept when receiver disabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_r[ssf_pkg::BIT_MPB] <= ssf_pkg::STATUS_RESET[ssf_pkg::BIT_MPB];
		end else if (standby) begin
			status_r[ssf_pkg::BIT_MPB] <= 1'b0;
		end else if (rx_ok & ctrl_r[ssf_pkg::CTL_MP] & ~sync_mode) begin
			status_r[ssf_pkg::BIT_MPB] <= rx_char.mp_bit; // see RULE22 see RULE3
		end
	end

	// transmit multiproc bit: plain read-write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_r[ssf_pkg::BIT_TX_MULTIPROC_BIT] <= ssf_pkg::STATUS_RESET[ssf_pkg::BIT_TX_MULTIPROC_BIT];
		end else if (standby) begin
			status_r[ssf_pkg::BIT_TX_MULTIPROC_BIT] <= 1'b0;
		end else if (wr_st) begin
			status_r[ssf_pkg::BIT_TX_MULTIPROC_BIT] <= pwdata[ssf_pkg::BIT_TX_MULTIPROC_BIT]; // see RULE23
		end
	end

	// receive holding register; overrun keeps the older character
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_holding_reg_r <= 8'h00;
		end else if (rx_ok & ~status_r[ssf_pkg::BIT_RX_HOLDING_FULL_FLAG]) begin
			rx_holding_reg_r <= rx_char.data; // see RULE11 see RULE17 see RULE9
		end
	end

	// transmit holding register, from software or dma
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_holding_reg_r <= 8'h00;
		end else if (dma_tx_write) begin
			tx_holding_reg_r <= dma_tx_data;
		end else if (wr_tx) begin
			tx_holding_reg_r <= pwdata[7:0];
		end
	end

	// control register; standby bit survives so software can leave standby
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= ssf_pkg::CTRL_RESET[6:0];
		end else if (acc & pwrite & (paddr == ssf_pkg::ADDR_CTRL)) begin
			ctrl_r <= pwdata[6:0];
		end
	end

	// read mux
	always_comb begin
		rdata_nxt = 8'h00;
		unique case (paddr)
			ssf_pkg::ADDR_STATUS: rdata_nxt = status_r;
			ssf_pkg::ADDR_TXDATA: rdata_nxt = tx_holding_reg_r;
			ssf_pkg::ADDR_RXDATA: rdata_nxt = rx_holding_reg_r;
			ssf_pkg::ADDR_CTRL: rdata_nxt = {1'b0, ctrl_r};
			default: rdata_nxt = 8'h00;
		endcase
	end

	// apb answer: pready one cycle after penable rises, unmapped errors
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h00000000;
		end else begin
			pready_r <= acc;
			pslverr_r <= acc & (paddr > ssf_pkg::ADDR_CTRL | paddr[1:0] != 2'h0);
			prdata_r <= acc ? {24'h000000, rdata_nxt} : 32'h00000000;
		end
	end

	// outputs, registered
	logic tx_allowed_r;
	logic rx_allowed_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_allowed_r <= 1'b0;
			rx_allowed_r <= 1'b0;
		end else begin
			tx_allowed_r <= ctrl_r[ssf_pkg::CTL_TE] & ~(sync_mode & rx_err_block); // see RULE14
			rx_allowed_r <= ctrl_r[ssf_pkg::CTL_RE] & ~rx_err_block; // see RULE18
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign tx_holding_reg = tx_holding_reg_r;
	assign tx_multiproc_bit = status_r[ssf_pkg::BIT_TX_MULTIPROC_BIT];
	assign transmitter_enable = ctrl_r[ssf_pkg::CTL_TE];
	assign receiver_enable = ctrl_r[ssf_pkg::CTL_RE];
	assign tx_allowed = tx_allowed_r;
	assign rx_allowed = rx_allowed_r;
endmodule : ssf_status

// file: verif/ssf_line_model.sv
// behavioural model of the shifters and the far end of the line
`timescale 1ns/1ps
module ssf_line_model (
	// clock
	input wire logic pclk,
	// events toward the status block
	output ssf_pkg::ssf_tx_evt_type tx_evt,
	output logic rx_done,
	output ssf_pkg::ssf_rx_char_type rx_char
);
	// quiet line at time zero
	initial begin
		tx_evt = '0;
		rx_done = 1'b0;
		rx_char = '0;
	end
	// one received character, fields scrambled once handed over
	task automatic send(input logic [7:0] d, input logic s1, input logic s2);
		@(posedge pclk);
		rx_done <= 1'b1;
		rx_char <= '{data: d, parity_bit: ^d, mp_bit: d[0], stop1: s1, stop2: s2};
		@(posedge pclk);
		rx_done <= 1'b0;
		rx_char <= ~rx_char;
	endtask : send
	// holding register taken into the shift register
	task automatic load();
		@(posedge pclk);
		tx_evt.load <= 1'b1;
		@(posedge pclk);
		tx_evt.load <= 1'b0;
	endtask : load
endmodule : ssf_line_model

// file: verif/ssf_status_chk.sv
// port assertions for the serial status block
`timescale 1ns/1ps
module ssf_status_chk (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// dma and shifter side
	input wire logic dma_tx_write,
	input wire logic [7:0] dma_tx_data,
	input wire logic [7:0] tx_holding_reg,
	input wire logic tx_multiproc_bit,
	input wire logic transmitter_enable,
	input wire logic receiver_enable
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic stby_r;
	// edge at which a transfer is taken
	sequence acc_s;
		psel && penable && !pready;
	endsequence
	sequence wr_s(logic [7:0] a);
		acc_s ##0 (pwrite && paddr == a);
	endsequence
	// standby shadow, status writes are void while it is held
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stby_r <= 1'b0;
		end else if (psel && penable && !pready && pwrite && paddr == ssf_pkg::ADDR_CTRL) begin
			stby_r <= pwdata[ssf_pkg::CTL_STBY];
		end
	end
	ans_once_a: assert property (acc_s |=> pready ##1 !pready) else $error("bad answer");
	err_rdy_a: assert property (pslverr |-> pready) else $error("error without ready");
	idle_rdata_a: assert property (!pready |-> prdata == 32'h0) else $error("stray read data");
	upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper bits");
	tx_multiproc_bit_wr_a: assert property (wr_s(ssf_pkg::ADDR_STATUS) ##0 !stby_r
		|=> tx_multiproc_bit == $past(pwdata[0])) else $error("tx multiproc bit");
	ctl_wr_a: assert property (wr_s(ssf_pkg::ADDR_CTRL) |=> transmitter_enable == $past(pwdata[0])
		&& receiver_enable == $past(pwdata[1])) else $error("enables");
	dma_load_a: assert property (dma_tx_write
		|=> tx_holding_reg == $past(dma_tx_data)) else $error("dma load");
	stby_rd_a: assert property (acc_s ##0 (stby_r && !pwrite && paddr == ssf_pkg::ADDR_STATUS)
		|=> prdata[7:0] == 8'h84) else $error("standby status");
endmodule : ssf_status_chk
bind ssf_status ssf_status_chk chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .dma_tx_write(dma_tx_write), .dma_tx_data(dma_tx_data),
	.tx_holding_reg(tx_holding_reg), .tx_multiproc_bit(tx_multiproc_bit),
	.transmitter_enable(transmitter_enable), .receiver_enable(receiver_enable));

// file: verif/ssf_status_test.sv
// self-checking bench for the serial status flag block
`timescale 1ns/1ps
module ssf_status_test;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr, dma_tx_data, tx_holding_reg, d1, d2, d3;
	logic [31:0] pwdata, prdata;
	logic dma_tx_write, dma_rx_read, rx_done, tx_multiproc_bit, transmitter_enable;
	logic receiver_enable, tx_allowed, rx_allowed;
	ssf_pkg::ssf_tx_evt_type tx_evt;
	ssf_pkg::ssf_rx_char_type rx_char;
	int n_mismatch = 0, total_checks = 0, cyc = 0;
	logic [17:0] exp_q[$];
	logic [17:0] en;
	ssf_line_model mdl (.pclk(pclk), .tx_evt(tx_evt), .rx_done(rx_done), .rx_char(rx_char));
	ssf_status dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .dma_tx_write(dma_tx_write), .dma_tx_data(dma_tx_data),
		.dma_rx_read(dma_rx_read), .tx_evt(tx_evt), .rx_done(rx_done), .rx_char(rx_char),
		.tx_holding_reg(tx_holding_reg), .tx_multiproc_bit(tx_multiproc_bit),
		.transmitter_enable(transmitter_enable), .receiver_enable(receiver_enable),
		.tx_allowed(tx_allowed), .rx_allowed(rx_allowed));
	// 25 MHz clock
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : conclude
	// one apb transfer; notes {write, error, expected byte, mask}
	task automatic apb(input logic w, input logic [7:0] a, d, e, m);
		exp_q.push_back({w, a > ssf_pkg::ADDR_CTRL, e, m});
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// dma strobe, tx write or rx read
	task automatic dma(input logic wr, input logic [7:0] d);
		@(posedge pclk);
		dma_tx_write <= wr;
		dma_rx_read <= !wr;
		dma_tx_data <= d;
		@(posedge pclk);
		dma_tx_write <= 1'b0;
		dma_rx_read <= 1'b0;
	endtask : dma
	// answer monitor and hang guard
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			conclude();
		end
		if (pready === 1'b1) begin
			en = exp_q.pop_front();
			chk("slave error", {31'h0, pslverr}, {31'h0, en[16]});
			if (!en[17]) chk("read data", prdata & {24'hffffff, en[7:0]}, {24'h0, en[15:8]});
		end
	end
	// main sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		dma_tx_write = 1'b0;
		dma_rx_read = 1'b0;
		dma_tx_data = 8'h00;
		void'($urandom(89843));
		d1 = 8'($urandom);
		d2 = 8'($urandom);
		d3 = 8'($urandom);
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(1, ssf_pkg::ADDR_STATUS, 8'h7b, 0, 0);
		apb(0, ssf_pkg::ADDR_STATUS, 0, 8'h85, 8'hff);
		apb(1, ssf_pkg::ADDR_STATUS, 8'h00, 0, 0);
		apb(0, ssf_pkg::ADDR_STATUS, 0, 8'h00, 8'hfb);
		$display("test software clear done");
		apb(1, ssf_pkg::ADDR_CTRL, 8'h03, 0, 0);
		mdl.load();
		apb(0, ssf_pkg::ADDR_STATUS, 0, 8'h80, 8'h80);
		dma(1, d1);
		#1 chk("holding", {24'h0, tx_holding_reg}, {24'h0, d1});
		apb(0, ssf_pkg::ADDR_STATUS, 0, 8'h00, 8'h80);
		$display("test transmit done");
		mdl.send(d2, 1, 1);
		apb(0, ssf_pkg::ADDR_STATUS, 0, 8'h40, 8'h78);
		mdl.send(d3, 1, 1);
		apb(0, ssf_pkg::ADDR_STATUS, 0, 8'h60, 8'h78);
		apb(0, ssf_pkg::ADDR_RXDATA, 0, d2, 8'hff);
		chk("rx allowed", {31'h0, rx_allowed}, 32'h0);
		chk("tx allowed", {31'h0, tx_allowed}, 32'h1);
		dma(0, 0);
		apb(0, ssf_pkg::ADDR_STATUS, 0, 8'h20, 8'h78);
		apb(1, ssf_pkg::ADDR_STATUS, 8'h00, 0, 0);
		apb(0, ssf_pkg::ADDR_STATUS, 0, 8'h00, 8'h78);
		$display("test overrun done");
		mdl.send(d1, 1, 0);
		apb(0, ssf_pkg::ADDR_STATUS, 0, 8'h40, 8'h78);
		dma(0, 0);
		mdl.send(d3, 0, 1);
		apb(0, ssf_pkg::ADDR_STATUS, 0, 8'h10, 8'h78);
		apb(0, ssf_pkg::ADDR_RXDATA, 0, d3, 8'hff);
		apb(1, ssf_pkg::ADDR_CTRL, 8'h00, 0, 0);
		apb(0, ssf_pkg::ADDR_STATUS, 0, 8'h94, 8'hfc);
		$display("test framing done");
		apb(0, 8'h10, 0, 0, 8'hff);
		apb(1, ssf_pkg::ADDR_CTRL, 8'h40, 0, 0);
		apb(0, ssf_pkg::ADDR_STATUS, 0, 8'h84, 8'hff);
		$display("test standby done");
		conclude();
	end
endmodule : ssf_status_test
